// [bench/led_check_sva.sv]
`timescale 1ns/1ps
module led_check_sva (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic thermal_shutdown,
	input wire logic supercap_bias_enable,
	input wire logic [1:0] drain_fault,
	input wire logic [1:0] test_bias_enable,
	input wire logic [1:0] led_output_enable,
	input wire logic flash_launch,
	input wire logic torch_launch,
	input wire logic charge_pump_on,
	input wire logic supercap_bias_on,
	input wire logic [7:0] status_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Window length counter
	// ----------------------------------------
	logic [9:0] win_reg;
	logic [9:0] win_next;
	assign win_next = (|test_bias_enable) ? win_reg + 10'h001 : 10'h000;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) win_reg <= 10'h000;
		else win_reg <= win_next;
	end
	// Eight cycles of margin covers the input synchroniser and the reset release
	sequence s_hot; thermal_shutdown [*8]; endsequence
	sequence s_end; $fell(|test_bias_enable); endsequence
	property p_pump_off; s_hot |-> !charge_pump_on; endproperty
	property p_no_launch; s_hot |-> !flash_launch && !torch_launch; endproperty
	property p_therm_flag; s_hot |-> status_value[6]; endproperty
	property p_cap_on; supercap_bias_enable [*8] |-> supercap_bias_on; endproperty
	property p_win_len; s_end |-> win_reg == 10'(led_check_pkg::SHORT_TEST_CYCLES); endproperty
	property p_win_max; win_reg <= 10'(led_check_pkg::SHORT_TEST_CYCLES); endproperty
	property p_busy; (|test_bias_enable) |-> status_value[7]; endproperty
	property p_short_off; (led_output_enable & status_value[1:0] & $past(status_value[1:0])) == 2'b00; endproperty
	property p_drain; drain_fault[0] [*8] |-> status_value[4]; endproperty
	property p_drain_one; drain_fault[1] [*8] |-> status_value[5]; endproperty
	a_pump_off: assert property (p_pump_off) else $error("pump on in shutdown");
	a_no_launch: assert property (p_no_launch) else $error("launch in shutdown");
	a_therm_flag: assert property (p_therm_flag) else $error("thermal flag missing");
	a_cap_on: assert property (p_cap_on) else $error("supercap bias off");
	a_win_len: assert property (p_win_len) else $error("test window length wrong");
	a_win_max: assert property (p_win_max) else $error("test window too long");
	a_busy: assert property (p_busy) else $error("busy flag missing");
	a_short_off: assert property (p_short_off) else $error("shorted LED driven");
	a_drain: assert property (p_drain) else $error("drain fault not flagged");
	a_drain_one: assert property (p_drain_one) else $error("second drain fault not flagged");
endmodule
bind led_fault_check_sequencer led_check_sva chk (.sys_clk, .rst_b, .thermal_shutdown, .supercap_bias_enable,
	.drain_fault, .test_bias_enable, .led_output_enable, .flash_launch, .torch_launch, .charge_pump_on,
	.supercap_bias_on, .status_value);

// [bench/mcu_model.sv]
`timescale 1ns/1ps
module mcu_model (
	input wire logic sys_clk,
	input wire logic [7:0] status_value,
	output logic led_check_launch,
	output logic check_cmd
);
	initial begin
		led_check_launch = 1'b0;
		check_cmd = 1'b0;
	end
	task launch; begin
		@(posedge sys_clk); #2 led_check_launch = 1'b0;
		repeat (4) @(posedge sys_clk); #2 led_check_launch = 1'b1;
	end endtask
	task command; begin
		@(posedge sys_clk); #2 check_cmd = 1'b0;
		repeat (4) @(posedge sys_clk); #2 check_cmd = 1'b1;
	end endtask
	// Register read only samples the value; writes to status are never issued
	task read_status(output logic [7:0] v); begin
		@(posedge sys_clk); #2 v = status_value;
	end endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic sys_clk, rst_b, check_cmd, led_check_launch, led_one_enable, led_two_enable, flash_request, torch_request;
	logic charge_pump_enable, supercap_bias_enable, thermal_shutdown, fault_clear, flash_launch, torch_launch;
	logic charge_pump_on, supercap_bias_on;
	logic [1:0] short_detect, open_detect, drain_fault, test_bias_enable, led_output_enable;
	logic [7:0] status_value, st;
	int n_mismatch, cmp_count, cyc, n;
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	mcu_model MCU (.sys_clk, .status_value, .led_check_launch, .check_cmd);
	led_fault_check_sequencer DUT (.sys_clk, .rst_b, .led_check_launch, .check_cmd, .led_one_enable, .led_two_enable,
		.flash_request, .torch_request, .charge_pump_enable, .supercap_bias_enable, .thermal_shutdown, .short_detect,
		.open_detect, .drain_fault, .fault_clear, .test_bias_enable, .led_output_enable, .flash_launch, .torch_launch,
		.charge_pump_on, .supercap_bias_on, .status_value);
	task results; begin
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	end endtask
	task chk(input logic [15:0] got, input logic [15:0] exp); begin
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	end endtask
	task automatic step(input int k); begin
		repeat (k) @(posedge sys_clk); #2;
	end endtask
	// Counts high samples of the bias window; bounded so a stuck window cannot hang
	task measure; begin
		n = 0;
		while ((|test_bias_enable) !== 1'b1 && n < 50) begin step(1); n++; end
		chk(16'(test_bias_enable), 16'h0003);
		chk(16'(status_value[7]), 16'h0001);
		n = 0;
		while ((|test_bias_enable) === 1'b1 && n < 900) begin step(1); n++; end
		chk(16'(n), 16'h0320);
	end endtask
	task t_short; begin
		short_detect = 2'b01; led_one_enable = 1'b1; led_two_enable = 1'b1;
		MCU.launch();
		fork begin step(100); MCU.launch(); end join_none
		measure();
		step(20); chk(16'(test_bias_enable), 16'h0000);
		MCU.read_status(st); chk(16'(st[1:0]), 16'h0001);
		short_detect = 2'b00; flash_request = 1'b1;
		step(6); chk(16'(led_output_enable), 16'h0002);
		chk(16'(flash_launch), 16'h0001);
		MCU.command(); step(6);
		chk(16'(test_bias_enable), 16'h0000);
		flash_request = 1'b0;
	end endtask
	task t_check; begin
		led_one_enable = 1'b0; led_two_enable = 1'b0; fault_clear = 1'b1;
		step(4); fault_clear = 1'b0; open_detect = 2'b10;
		step(4); chk(16'(status_value[1:0]), 16'h0000);
		MCU.command(); measure();
		MCU.read_status(st); chk(16'(st[3:2]), 16'h0002);
		open_detect = 2'b00;
	end endtask
	task t_hot; begin
		charge_pump_enable = 1'b1; supercap_bias_enable = 1'b1;
		step(10); chk(16'(charge_pump_on), 16'h0001);
		thermal_shutdown = 1'b1; flash_request = 1'b1; torch_request = 1'b1;
		step(10); chk(16'({charge_pump_on, flash_launch, torch_launch, supercap_bias_on}), 16'h0001);
		chk(16'(status_value[6]), 16'h0001);
		thermal_shutdown = 1'b0; flash_request = 1'b0; torch_request = 1'b0;
		step(10); chk(16'(charge_pump_on), 16'h0001);
	end endtask
	task t_drain; begin
		drain_fault = 2'b10; step(8); drain_fault = 2'b00;
		step(4); chk(16'(status_value[5:4]), 16'h0002);
	end endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin n_mismatch++; results(); end
	end
	initial begin
		{rst_b, led_one_enable, led_two_enable, flash_request, torch_request, charge_pump_enable} = '0;
		{supercap_bias_enable, thermal_shutdown, fault_clear, short_detect, open_detect, drain_fault} = '0;
		step(4); rst_b = 1'b1; step(4);
		t_short(); t_check(); t_hot(); t_drain();
		results();
	end
endmodule

// [hw/edge_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of levels; rising-edge pulse from the settled copy.
module edge_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic [W-1:0] rise_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign sync_out = sync_reg;
	assign rise_out = sync_reg & ~prev_reg;
endmodule

// [hw/led_check_pkg.sv]
package led_check_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_FREQ_HZ = 40000000;
	localparam int SHORT_TEST_US = 20;
	// Longest window, rounded down to whole cycles
	localparam int SHORT_TEST_CYCLES = SHORT_TEST_US * (CLK_FREQ_HZ / 1000000);
	localparam int TEST_CNT_W = 10;
	localparam logic [TEST_CNT_W-1:0] TEST_CNT_LAST = TEST_CNT_W'(SHORT_TEST_CYCLES - 1);
	localparam logic [TEST_CNT_W-1:0] TEST_CNT_ZERO = 10'h000;

	// ----------------------------------------
	// Channels and status layout
	// ----------------------------------------
	localparam int NUM_LEDS = 2;
	localparam int STAT_W = 8;
	localparam int STAT_SHORT_LSB = 0;
	localparam int STAT_OPEN_LSB = 2;
	localparam int STAT_DRAIN_LSB = 4;
	localparam int STAT_THERMAL_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHORT_TEST = 3'b010,
		ST_CONN_CHECK = 3'b100
	} check_state_e;

endpackage

// [hw/led_fault_check_sequencer.sv]
`timescale 1ns/1ps
module led_fault_check_sequencer (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic led_check_launch,
	input wire logic check_cmd,
	input wire logic led_one_enable,
	input wire logic led_two_enable,
	input wire logic flash_request,
	input wire logic torch_request,
	input wire logic charge_pump_enable,
	input wire logic supercap_bias_enable,
	input wire logic thermal_shutdown,
	input wire logic [1:0] short_detect,
	input wire logic [1:0] open_detect,
	input wire logic [1:0] drain_fault,
	input wire logic fault_clear,
	output logic [1:0] test_bias_enable,
	output logic [1:0] led_output_enable,
	output logic flash_launch,
	output logic torch_launch,
	output logic charge_pump_on,
	output logic supercap_bias_on,
	output logic [7:0] status_value
);
	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	localparam int SYNC_W = 13;
	logic [SYNC_W-1:0] sync_lvl;
	logic [SYNC_W-1:0] sync_rise;

	// Control and analog comparator inputs cross in here; launch has its own, the pump and supercap enables are used raw
	edge_sync #(.W(SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({fault_clear, thermal_shutdown, drain_fault, open_detect, short_detect,
			torch_request, flash_request, led_two_enable, led_one_enable, check_cmd}),
		.sync_out(sync_lvl),
		.rise_out(sync_rise)
	);

	// Only the edge of the launch bit matters, never its level
	logic launch_rise;
	edge_sync #(.W(1)) u_launch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(led_check_launch),
		.sync_out(),
		.rise_out(launch_rise)
	);

	logic cmd_rise;
	logic en_one;
	logic en_two;
	logic flash_req_s;
	logic torch_req_s;
	logic therm_s;
	logic clr_rise;
	logic [1:0] short_s;
	logic [1:0] open_s;
	logic [1:0] drain_s;
	assign cmd_rise = sync_rise[0];
	assign en_one = sync_lvl[1];
	assign en_two = sync_lvl[2];
	assign flash_req_s = sync_lvl[3];
	assign torch_req_s = sync_lvl[4];
	assign short_s = sync_lvl[6:5];
	assign open_s = sync_lvl[8:7];
	assign drain_s = sync_lvl[10:9];
	assign therm_s = sync_lvl[11];
	assign clr_rise = sync_rise[12];

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		led_check_pkg::check_state_e state;
		logic [led_check_pkg::TEST_CNT_W-1:0] count;
		logic [1:0] short_flt;
		logic [1:0] open_flt;
		logic [1:0] drain_flt;
		logic [1:0] disabled;
		logic [1:0] bias;
		logic flash_go;
		logic torch_go;
		logic pump_on;
		logic bias_on;
		logic [7:0] status;
	} seq_s;

	seq_s s_reg;
	seq_s s_next;
	logic seq_active;

	// Flash or torch running means a connectivity check command is dropped
	assign seq_active = s_reg.flash_go | s_reg.torch_go;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Bias rises together with the state, so the window spans the full count
	always_comb begin
		s_next = s_reg;
		s_next.bias = 2'b00;
		unique case (s_reg.state)
			led_check_pkg::ST_IDLE: begin
				if (launch_rise) begin
					s_next.state = led_check_pkg::ST_SHORT_TEST;
					s_next.count = led_check_pkg::TEST_CNT_ZERO;
					s_next.bias = 2'b11;
				end else if (cmd_rise && !seq_active) begin
					s_next.state = led_check_pkg::ST_CONN_CHECK;
					s_next.count = led_check_pkg::TEST_CNT_ZERO;
					s_next.bias = 2'b11;
				end
			end
			led_check_pkg::ST_SHORT_TEST: begin
				// Launch edges are not looked at here, so a retrigger is dropped
				s_next.bias = 2'b11;
				s_next.count = s_reg.count + 1'b1;
				if (s_reg.count == led_check_pkg::TEST_CNT_LAST) begin
					s_next.state = led_check_pkg::ST_IDLE;
					s_next.bias = 2'b00;
					s_next.short_flt = s_reg.short_flt | short_s;
					s_next.disabled = s_reg.disabled | short_s;
				end
			end
			led_check_pkg::ST_CONN_CHECK: begin
				// Runs regardless of the enable bits
				s_next.bias = 2'b11;
				s_next.count = s_reg.count + 1'b1;
				if (s_reg.count == led_check_pkg::TEST_CNT_LAST) begin
					s_next.state = led_check_pkg::ST_IDLE;
					s_next.bias = 2'b00;
					s_next.open_flt = s_reg.open_flt | open_s;
					s_next.short_flt = s_reg.short_flt | short_s;
					s_next.disabled = s_reg.disabled | open_s | short_s;
				end
			end
			default: begin
				s_next.state = led_check_pkg::ST_IDLE;
			end
		endcase

		// Continuous drain supervision, set wins over the clear below
		if (clr_rise && s_reg.state == led_check_pkg::ST_IDLE) begin
			s_next.short_flt = 2'b00;
			s_next.open_flt = 2'b00;
			s_next.disabled = 2'b00;
			s_next.drain_flt = drain_s;
		end else begin
			s_next.drain_flt = s_reg.drain_flt | drain_s;
		end

		// No power launch while testing or hot; charge pump also off when hot, supercap bias untouched
		s_next.flash_go = flash_req_s && !therm_s && s_next.state == led_check_pkg::ST_IDLE;
		s_next.torch_go = torch_req_s && !therm_s && s_next.state == led_check_pkg::ST_IDLE;
		s_next.pump_on = charge_pump_enable && !therm_s;
		s_next.bias_on = supercap_bias_enable;

		// Read-only image: only hardware writes it
		s_next.status = 8'h00;
		s_next.status[led_check_pkg::STAT_SHORT_LSB +: led_check_pkg::NUM_LEDS] = s_next.short_flt;
		s_next.status[led_check_pkg::STAT_OPEN_LSB +: led_check_pkg::NUM_LEDS] = s_next.open_flt;
		s_next.status[led_check_pkg::STAT_DRAIN_LSB +: led_check_pkg::NUM_LEDS] = s_next.drain_flt;
		s_next.status[led_check_pkg::STAT_THERMAL_BIT] = therm_s;
		s_next.status[led_check_pkg::STAT_BUSY_BIT] = s_next.state != led_check_pkg::ST_IDLE;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Faults are sticky; only the clear input, seen while idle, drops them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{state: led_check_pkg::ST_IDLE, count: led_check_pkg::TEST_CNT_ZERO, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// A disabled LED stays dark through later launches until its fault is cleared
	assign test_bias_enable = s_reg.bias;
	assign led_output_enable = {en_two, en_one} & ~s_reg.disabled & {2{s_reg.torch_go | s_reg.flash_go}};
	assign flash_launch = s_reg.flash_go;
	assign torch_launch = s_reg.torch_go;
	assign charge_pump_on = s_reg.pump_on;
	assign supercap_bias_on = s_reg.bias_on;
	assign status_value = s_reg.status;
endmodule
